/* File: rtl/switch_config_pkg.sv */
package switch_config_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] reg_config_ofs = 8'h00;
  localparam logic [7:0] reg_status_ofs = 8'h04;
  localparam logic [7:0] reg_irq_status_ofs = 8'h08;
  localparam logic [7:0] reg_irq_mask_ofs = 8'h0C;
  localparam logic [7:0] reg_control_ofs = 8'h10;
  localparam logic [7:0] reg_drive_ofs = 8'h14;

  // Field positions inside the config register.
  localparam int node_address_pos = 0;
  localparam int bit_rate_pos = 8;
  localparam int process_words_pos = 12;
  localparam int io_enable_pos = 16;
  localparam int variant_pos = 17;

  // Field positions inside the status register.
  localparam int init_pos = 0;
  localparam int bad_rate_pos = 1;
  localparam int bad_length_pos = 2;
  localparam int connected_pos = 3;

  // Interrupt status and mask bits.
  localparam int irq_ready_bit = 0;
  localparam int irq_bad_rate_bit = 1;
  localparam int irq_bad_length_bit = 2;
  localparam int irq_connected_bit = 3;
  localparam int irq_width = 4;

  // Control register bits.
  localparam int ctl_master_config_pos = 0;
  localparam int ctl_program_run_pos = 1;
  localparam int ctl_bus_ramp_pos = 2;

  localparam logic [3:0] irq_mask_reset = 4'h0;
  localparam logic [2:0] control_reset = 3'h0;

  // Bit rate codes and their baud values in kbaud.
  localparam logic [1:0] rate_code_125 = 2'h0;
  localparam logic [1:0] rate_code_250 = 2'h1;
  localparam logic [1:0] rate_code_500 = 2'h2;
  localparam logic [1:0] rate_code_reserved = 2'h3;
  localparam logic [9:0] rate_kbaud_125 = 10'd125;
  localparam logic [9:0] rate_kbaud_250 = 10'd250;
  localparam logic [9:0] rate_kbaud_500 = 10'd500;

  // Switch value the factory ships: address 63, 500 kbaud.
  localparam logic [7:0] network_bank_factory = 8'hFE;

  localparam logic [3:0] gateway_words_min = 4'h1;
  localparam logic [3:0] gateway_words_max = 4'hA;
  localparam logic [3:0] selector_max = 4'hA;

  // Indicator timing: flash half period and lamp test length.
  localparam int clk_hz = 125_000_000;
  localparam int flash_half_ms = 250;
  localparam int lamp_test_ms = 500;
  localparam int flash_half_cycles = clk_hz / 1000 * flash_half_ms;
  localparam int lamp_test_cycles = clk_hz / 1000 * lamp_test_ms;

  // Two-bit lamp colour: off, green, red.
  typedef enum logic [1:0] {lamp_off, lamp_green, lamp_red} lamp_type;

  typedef struct packed {
    lamp_type network;
    lamp_type polled;
    lamp_type strobe;
    logic fault;
  } indicator_type;

  typedef struct packed {
    logic [5:0] node_address;
    logic [1:0] bit_rate;
    logic [3:0] process_words;
    logic io_enable;
  } config_type;

  typedef struct packed {
    logic cw_enable;
    logic ccw_enable;
  } direction_type;

  typedef struct packed {
    logic run;
    logic cw_allowed;
    logic ccw_allowed;
  } drive_gate_type;

endpackage : switch_config_pkg

/* File: rtl/selector_table.sv */
`timescale 1ns/100ps
// Registered lookup of the two rotary selectors, in Hz and tenths.
module selector_table
  import switch_config_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] min_frequency_selector,
  input wire logic [3:0] ramp_time_selector,
  output logic [5:0] min_frequency_hz,
  output logic [6:0] ramp_tenths
);

  logic [5:0] next_min_frequency_hz;
  logic [6:0] next_ramp_tenths;

  always_comb begin
    case (min_frequency_selector)
      4'h0: next_min_frequency_hz = 6'd2;
      4'h1: next_min_frequency_hz = 6'd5;
      4'h2: next_min_frequency_hz = 6'd7;
      4'h3: next_min_frequency_hz = 6'd10;
      4'h4: next_min_frequency_hz = 6'd12;
      4'h5: next_min_frequency_hz = 6'd15;
      4'h6: next_min_frequency_hz = 6'd20;
      4'h7: next_min_frequency_hz = 6'd25;
      4'h8: next_min_frequency_hz = 6'd30;
      4'h9: next_min_frequency_hz = 6'd35;
      default: next_min_frequency_hz = 6'd40;
    endcase
    // The table is not monotonic at positions 1 and 2.
    case (ramp_time_selector)
      4'h0: next_ramp_tenths = 7'd1;
      4'h1: next_ramp_tenths = 7'd3;
      4'h2: next_ramp_tenths = 7'd2;
      4'h3: next_ramp_tenths = 7'd5;
      4'h4: next_ramp_tenths = 7'd7;
      4'h5: next_ramp_tenths = 7'd10;
      4'h6: next_ramp_tenths = 7'd20;
      4'h7: next_ramp_tenths = 7'd30;
      4'h8: next_ramp_tenths = 7'd50;
      4'h9: next_ramp_tenths = 7'd70;
      default: next_ramp_tenths = 7'd100;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      min_frequency_hz <= 6'd0;
      ramp_tenths <= 7'd0;
    end else begin
      min_frequency_hz <= next_min_frequency_hz;
      ramp_tenths <= next_ramp_tenths;
    end
  end

endmodule : selector_table

/* File: rtl/fieldbus_switch_config_decoder.sv */
`timescale 1ns/100ps
// What this block does
// - Bit-rate switches: off/off 125k, first 250k, second 500k, both reserved.
// - Six address switches form node address 0..63, lowest weight one.
// - Factory default switch setting gives address 63 at 500 kbaud.
// - Gateway: reserved bit rate holds init and flashes polled lamp red.
// - Motor variant: I/O enable switch off disables, on enables local I/O.
// - Motor variant: two switches give zero to three process data words.
// - Gateway: four switches give length; 1..10 valid, others reserved.
// - Reserved length holds init and flashes bit-strobe lamp red.
// - Ramp selector maps positions 0..10 to times for a 50 Hz step.
// - Ramp selector used only when the fieldbus does not supply ramp.
// - One direction input stops opposite setpoints; none blocks the drive.
// - Bus connect runs lamp test, then network flashes green; fault lamp clears (gateway: once program runs).
// - After master download, lamps show master and process connections.
module fieldbus_switch_config_decoder
  import switch_config_pkg::*;
#(
  parameter int flash_cycles = flash_half_cycles,
  parameter int test_cycles = lamp_test_cycles
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic gateway_variant,
  input wire logic [7:0] network_switch_bank,
  input wire logic [3:0] process_switch_bank,
  input wire logic [3:0] min_frequency_selector,
  input wire logic [3:0] ramp_time_selector,
  input wire direction_type direction_in,
  input wire logic bus_cable_present,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  output config_type active_config,
  output logic [9:0] bit_rate_kbaud,
  output logic config_valid,
  output logic local_io_enable,
  output indicator_type indicators,
  output drive_gate_type drive_gate,
  output logic [5:0] min_frequency_hz,
  output logic [6:0] ramp_tenths
);

  typedef enum {st_init, st_lamp_test, st_wait_master, st_online} state_type;

  // Pin synchronisers: the first stage feeds only the second.
  logic [19:0] pins_meta;
  logic [19:0] pins_sync;
  logic [7:0] net_bank;
  logic [3:0] proc_bank;
  logic [3:0] min_sel;
  logic [3:0] ramp_sel;
  logic gateway;
  logic cable;
  direction_type dir;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pins_meta <= 20'h00000;
      pins_sync <= 20'h00000;
    end else begin
      pins_meta <= {network_switch_bank, process_switch_bank,
                    min_frequency_selector, ramp_time_selector};
      pins_sync <= pins_meta;
    end
  end

  logic [3:0] misc_meta;
  logic [3:0] misc_sync;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      misc_meta <= 4'h0;
      misc_sync <= 4'h0;
    end else begin
      misc_meta <= {gateway_variant, bus_cable_present, direction_in};
      misc_sync <= misc_meta;
    end
  end

  assign net_bank = pins_sync[19:12];
  assign proc_bank = pins_sync[11:8];
  assign min_sel = pins_sync[7:4];
  assign ramp_sel = pins_sync[3:0];
  assign gateway = misc_sync[3];
  assign cable = misc_sync[2];
  assign dir = misc_sync[1:0];

  // Decoding helpers: rate for the held config, length check for the live switches.
  function automatic logic [9:0] rate_kbaud(input logic [1:0] code);
    case (code)
      rate_code_125: rate_kbaud = rate_kbaud_125;
      rate_code_250: rate_kbaud = rate_kbaud_250;
      rate_code_500: rate_kbaud = rate_kbaud_500;
      default: rate_kbaud = 10'd0;
    endcase
  endfunction : rate_kbaud

  function automatic logic words_ok(input logic gw, input logic [3:0] w);
    if (gw) begin
      words_ok = (w >= gateway_words_min) && (w <= gateway_words_max);
    end else begin
      words_ok = 1'b1;
    end
  endfunction : words_ok

  // Live decode of the synchronised switches.
  config_type live_config;
  logic live_bad_rate;
  logic live_bad_length;

  always_comb begin
    live_config.bit_rate = net_bank[1:0];
    live_config.node_address = net_bank[7:2];
    live_config.io_enable = gateway ? 1'b0 : proc_bank[2];
    live_config.process_words = gateway ? proc_bank
                                        : {2'b00, proc_bank[1:0]};
    // Only the gateway treats the reserved rate as an init blocker.
    live_bad_rate = gateway && (net_bank[1:0] == rate_code_reserved);
    live_bad_length = !words_ok(gateway, live_config.process_words);
  end

  // Wishbone registers.
  logic [irq_width-1:0] irq_status;
  logic [irq_width-1:0] irq_mask;
  logic [2:0] control;
  logic [irq_width-1:0] irq_event;
  logic [irq_width-1:0] next_irq_status;
  logic [irq_width-1:0] next_irq_mask;
  logic [2:0] next_control;
  logic [31:0] next_dat;
  logic next_ack;
  logic next_irq;
  logic access;
  logic wr;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = access && wb_we_i && wb_sel_i[0];

  // Main state machine and held configuration.
  state_type state;
  state_type next_state;
  config_type held;
  config_type next_held;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic bad_rate;
  logic bad_length;
  logic next_bad_rate;
  logic next_bad_length;

  always_comb begin
    next_state = state;
    next_held = held;
    next_timer = timer;
    next_bad_rate = bad_rate;
    next_bad_length = bad_length;
    irq_event = '0;
    case (state)
      st_init: begin
        // Keep resampling until the switches hold a legal setting and the cable is present.
        next_held = live_config;
        next_bad_rate = live_bad_rate;
        next_bad_length = live_bad_length;
        irq_event[irq_bad_rate_bit] = live_bad_rate && !bad_rate;
        irq_event[irq_bad_length_bit] = live_bad_length && !bad_length;
        if (!live_bad_rate && !live_bad_length && cable) begin
          next_state = st_lamp_test;
          next_timer = '0;
          irq_event[irq_ready_bit] = 1'b1;
        end
      end
      st_lamp_test: begin
        next_timer = timer + 32'd1;
        if (timer >= 32'(test_cycles - 1)) begin
          next_state = st_wait_master;
        end
      end
      st_wait_master: begin
        if (control[ctl_master_config_pos]) begin
          next_state = st_online;
          irq_event[irq_connected_bit] = 1'b1;
        end
      end
      st_online: begin
        if (!control[ctl_master_config_pos]) begin
          next_state = st_wait_master;
        end
      end
      default: next_state = st_init;
    endcase
    // Losing the cable sends the module back to re-read the switches.
    if (!cable && state != st_init) begin
      next_state = st_init;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= st_init;
      held <= '0;
      timer <= '0;
      bad_rate <= 1'b0;
      bad_length <= 1'b0;
    end else begin
      state <= next_state;
      held <= next_held;
      timer <= next_timer;
      bad_rate <= next_bad_rate;
      bad_length <= next_bad_length;
    end
  end

  // Flash divider: a one-cycle enable toggles the flash phase.
  logic [31:0] flash_count;
  logic [31:0] next_flash_count;
  logic flash;
  logic next_flash;

  always_comb begin
    next_flash_count = flash_count + 32'd1;
    next_flash = flash;
    if (flash_count >= 32'(flash_cycles - 1)) begin
      next_flash_count = '0;
      next_flash = !flash;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flash_count <= '0;
      flash <= 1'b0;
    end else begin
      flash_count <= next_flash_count;
      flash <= next_flash;
    end
  end

  // Register bus next values; a new event wins over a clear.
  always_comb begin
    next_irq_mask = irq_mask;
    next_control = control;
    next_irq_status = irq_status;
    if (wr && wb_adr_i[7:0] == reg_irq_mask_ofs) begin
      next_irq_mask = wb_dat_i[irq_width-1:0];
    end
    if (wr && wb_adr_i[7:0] == reg_control_ofs) begin
      next_control = wb_dat_i[2:0];
    end
    if (wr && wb_adr_i[7:0] == reg_irq_status_ofs) begin
      next_irq_status = irq_status & ~wb_dat_i[irq_width-1:0];
    end
    next_irq_status = next_irq_status | irq_event;
    next_irq = |(next_irq_status & next_irq_mask);
    next_ack = access;
    next_dat = 32'h00000000;
    if (access && !wb_we_i) begin
      case (wb_adr_i[7:0])
        reg_config_ofs: begin
          next_dat[node_address_pos +: 6] = held.node_address;
          next_dat[bit_rate_pos +: 2] = held.bit_rate;
          next_dat[process_words_pos +: 4] = held.process_words;
          next_dat[io_enable_pos] = held.io_enable;
          next_dat[variant_pos] = gateway;
        end
        reg_status_ofs: begin
          next_dat[init_pos] = (state == st_init);
          next_dat[bad_rate_pos] = bad_rate;
          next_dat[bad_length_pos] = bad_length;
          next_dat[connected_pos] = (state == st_online);
        end
        reg_irq_status_ofs: next_dat[irq_width-1:0] = irq_status;
        reg_irq_mask_ofs: next_dat[irq_width-1:0] = irq_mask;
        reg_control_ofs: next_dat[2:0] = control;
        reg_drive_ofs: begin
          next_dat[5:0] = min_frequency_hz;
          next_dat[14:8] = ramp_tenths;
        end
        default: next_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_status <= '0;
      irq_mask <= irq_mask_reset;
      control <= control_reset;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      control <= next_control;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      irq <= next_irq;
    end
  end

  // Outputs: indicators, drive gating and the decoded configuration.
  indicator_type next_indicators;
  drive_gate_type next_drive_gate;
  logic running;

  assign running = (state != st_init);

  always_comb begin
    next_indicators.network = lamp_off;
    next_indicators.polled = lamp_off;
    next_indicators.strobe = lamp_off;
    next_indicators.fault = 1'b1;
    case (state)
      st_init: begin
        if (bad_rate && flash) begin
          next_indicators.polled = lamp_red;
        end
        if (bad_length && flash) begin
          next_indicators.strobe = lamp_red;
        end
      end
      st_lamp_test: begin
        next_indicators.network = lamp_green;
        next_indicators.polled = lamp_green;
        next_indicators.strobe = lamp_green;
      end
      st_wait_master: begin
        next_indicators.network = flash ? lamp_green : lamp_off;
        // The gateway's fault lamp clears only with its program running.
        next_indicators.fault = gateway && !control[ctl_program_run_pos];
      end
      st_online: begin
        next_indicators.network = lamp_green;
        next_indicators.polled = lamp_green;
        next_indicators.strobe = lamp_green;
        next_indicators.fault = gateway && !control[ctl_program_run_pos];
      end
      default: next_indicators.fault = 1'b1;
    endcase
    // Neither direction input enabled blocks the drive outright.
    next_drive_gate.run = running && (dir.cw_enable || dir.ccw_enable);
    next_drive_gate.cw_allowed = running && dir.cw_enable;
    next_drive_gate.ccw_allowed = running && dir.ccw_enable;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      indicators <= '0;
      drive_gate <= '0;
      active_config <= '0;
      bit_rate_kbaud <= 10'd0;
      config_valid <= 1'b0;
      local_io_enable <= 1'b0;
    end else begin
      indicators <= next_indicators;
      drive_gate <= next_drive_gate;
      active_config <= held;
      bit_rate_kbaud <= rate_kbaud(held.bit_rate);
      config_valid <= running;
      local_io_enable <= running && held.io_enable;
    end
  end

  // The bus-supplied ramp takes precedence over the selector.
  logic [3:0] ramp_sel_used;
  assign ramp_sel_used = control[ctl_bus_ramp_pos] ? selector_max
                                                   : ramp_sel;

  selector_table u_selector_table (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .min_frequency_selector(min_sel),
    .ramp_time_selector(ramp_sel_used),
    .min_frequency_hz(min_frequency_hz),
    .ramp_tenths(ramp_tenths)
  );

endmodule : fieldbus_switch_config_decoder

/* File: tb/switch_scanner_model.sv */
`timescale 1ns/100ps
// Far side at power-up: the switch banks and the bus cable plug.
module switch_scanner_model (
  input wire logic clk_sys,
  input wire logic [7:0] req_network,
  input wire logic [3:0] req_process,
  input wire logic req_cable,
  output logic [7:0] network_switch_bank,
  output logic [3:0] process_switch_bank,
  output logic bus_cable_present
);
  initial begin
    network_switch_bank = 8'hFE;
    process_switch_bank = 4'h1;
    bus_cable_present = 1'b0;
  end

  // Pins only move just after an edge, as a debounced contact would.
  always @(posedge clk_sys) begin
    network_switch_bank <= req_network;
    process_switch_bank <= req_process;
    bus_cable_present <= req_cable;
  end
endmodule : switch_scanner_model

/* File: tb/switch_config_monitor.sv */
`timescale 1ns/100ps
module switch_config_monitor
  import switch_config_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic config_valid,
  input wire logic local_io_enable,
  input wire config_type active_config,
  input wire logic [9:0] bit_rate_kbaud,
  input wire indicator_type indicators,
  input wire drive_gate_type drive_gate,
  input wire logic [5:0] min_frequency_hz,
  input wire logic [6:0] ramp_tenths
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  ack_cause_a: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without a request");
  rate_decode_a: assert property (config_valid |-> bit_rate_kbaud == (
    active_config.bit_rate == 2'h0 ? 10'd125 :
    active_config.bit_rate == 2'h1 ? 10'd250 :
    active_config.bit_rate == 2'h2 ? 10'd500 : 10'd0))
    else $error("baud value does not match rate code");
  io_gate_a: assert property (
    local_io_enable |-> config_valid && active_config.io_enable)
    else $error("local io enabled without its switch");
  red_lamp_a: assert property (
    config_valid && $past(config_valid) |->
    indicators.polled != lamp_red && indicators.strobe != lamp_red)
    else $error("red setting lamp outside init");
  run_gate_a: assert property (
    drive_gate.run |-> drive_gate.cw_allowed || drive_gate.ccw_allowed)
    else $error("drive runs with no direction enabled");
  min_freq_a: assert property (config_valid |-> min_frequency_hz inside
    {6'd2, 6'd5, 6'd7, 6'd10, 6'd12, 6'd15, 6'd20, 6'd25, 6'd30, 6'd35,
    6'd40}) else $error("minimum frequency off the table");
  ramp_table_a: assert property (config_valid |-> ramp_tenths inside
    {7'd1, 7'd3, 7'd2, 7'd5, 7'd7, 7'd10, 7'd20, 7'd30, 7'd50, 7'd70,
    7'd100}) else $error("ramp time off the table");
  config_hold_a: assert property (
    config_valid && $past(config_valid) |-> $stable(active_config))
    else $error("held configuration moved outside init");
endmodule : switch_config_monitor

bind fieldbus_switch_config_decoder switch_config_monitor u_monitor (
  .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .config_valid(config_valid),
  .local_io_enable(local_io_enable), .active_config(active_config),
  .bit_rate_kbaud(bit_rate_kbaud), .indicators(indicators),
  .drive_gate(drive_gate), .min_frequency_hz(min_frequency_hz),
  .ramp_tenths(ramp_tenths));

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench
  import switch_config_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic gateway_variant = 1'b0;
  logic [3:0] min_sel = 4'h0;
  logic [3:0] ramp_sel = 4'h0;
  direction_type dir_in = '0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [7:0] req_net = 8'hFE;
  logic [3:0] req_proc = 4'h1;
  logic req_cable = 1'b0;
  logic [7:0] net_bank;
  logic [3:0] proc_bank;
  logic cable;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  config_type cfg;
  logic [9:0] kbaud;
  logic valid;
  logic io_en;
  indicator_type lamps;
  drive_gate_type gate;
  logic [5:0] fmin;
  logic [6:0] ramp;
  logic [31:0] q;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 32'h38990510;
  int kb_tab[4] = '{125, 250, 500, 0};
  int fmin_tab[11] = '{2, 5, 7, 10, 12, 15, 20, 25, 30, 35, 40};
  int ramp_tab[11] = '{1, 3, 2, 5, 7, 10, 20, 30, 50, 70, 100};

  always #4 clk_sys = ~clk_sys;

  switch_scanner_model partner (.clk_sys(clk_sys), .req_network(req_net),
    .req_process(req_proc), .req_cable(req_cable),
    .network_switch_bank(net_bank), .process_switch_bank(proc_bank),
    .bus_cable_present(cable));

  fieldbus_switch_config_decoder #(.flash_cycles(4), .test_cycles(8)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .gateway_variant(gateway_variant),
    .network_switch_bank(net_bank), .process_switch_bank(proc_bank),
    .min_frequency_selector(min_sel), .ramp_time_selector(ramp_sel),
    .direction_in(dir_in), .bus_cable_present(cable), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
    .active_config(cfg), .bit_rate_kbaud(kbaud), .config_valid(valid),
    .local_io_enable(io_en), .indicators(lamps), .drive_gate(gate),
    .min_frequency_hz(fmin), .ramp_tenths(ramp));

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step

  // The master never assumes a latency; it waits for ack, up to a bound of 20 cycles.
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= 32'(a);
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      final_report();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // Unplugging the cable is the only way back into init to reread switches.
  task load(input logic gw, input logic [7:0] nb, input logic [3:0] pb);
    int n;
    logic ok;
    logic seen;
    logic [3:0] words;
    ok = !gw || (nb[1:0] != 2'h3 && pb >= 4'h1 && pb <= 4'hA);
    words = gw ? pb : {2'b00, pb[1:0]};
    seen = 1'b0;
    step(1);
    req_cable <= 1'b0;
    gateway_variant <= gw;
    req_net <= nb;
    req_proc <= pb;
    step(8);
    req_cable <= 1'b1;
    n = 0;
    while (valid !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    check("config_valid", 32'(valid), 32'(ok));
    if (ok) begin
      check("node_address", 32'(cfg.node_address), 32'(nb[7:2]));
      check("bit_rate", 32'(cfg.bit_rate), 32'(nb[1:0]));
      check("kbaud", 32'(kbaud), 32'(kb_tab[nb[1:0]]));
      check("process_words", 32'(cfg.process_words), 32'(words));
      check("io_enable", 32'(io_en), 32'(!gw && pb[2]));
    end else begin
      repeat (12) begin
        step(1);
        if (nb[1:0] == 2'h3 && lamps.polled === lamp_red) seen = 1'b1;
        if (nb[1:0] != 2'h3 && lamps.strobe === lamp_red) seen = 1'b1;
      end
      check("red_lamp", 32'(seen), 32'h1);
      req_net <= 8'hFE;
      req_proc <= 4'h1;
      n = 0;
      while (valid !== 1'b1 && n < 20) begin
        step(1);
        n++;
      end
      check("init_left", 32'(valid), 32'h1);
    end
  endtask : load

  initial begin
    #400000;
    bad_count++;
    final_report();
  end

  initial begin
    logic g;
    logic o;
    step(6);
    rstn <= 1'b1;
    wb(reg_irq_mask_ofs, 1'b0, 32'h0);
    check("mask_reset", q, 32'h0);
    wb(reg_control_ofs, 1'b0, 32'h0);
    check("control_reset", q, 32'h0);
    wb(8'h40, 1'b0, 32'h0);
    check("unmapped", q, 32'h0);
    load(1'b0, 8'hFE, 4'h5);
    wb(reg_irq_status_ofs, 1'b0, 32'h0);
    check("ready_irq", 32'(q[irq_ready_bit]), 32'h1);
    wb(reg_config_ofs, 1'b0, 32'h0);
    check("config_reg", q, 32'h0001123F);
    check("irq_masked", 32'(irq), 32'h0);
    wb(reg_irq_mask_ofs, 1'b1, 32'h1);
    step(2);
    check("irq_raised", 32'(irq), 32'h1);
    wb(reg_irq_status_ofs, 1'b1, 32'h1);
    step(2);
    check("irq_cleared", 32'(irq), 32'h0);
    g = 1'b0;
    o = 1'b0;
    step(12);
    repeat (16) begin
      step(1);
      if (lamps.network === lamp_green) g = 1'b1;
      if (lamps.network === lamp_off) o = 1'b1;
    end
    check("network_flash", 32'({g, o}), 32'h3);
    check("fault_lamp", 32'(lamps.fault), 32'h0);
    wb(reg_control_ofs, 1'b1, 32'h1);
    step(3);
    check("online_lamps", 32'(lamps[6:1]), 32'h15);
    for (int i = 0; i <= 10; i++) begin
      min_sel <= 4'(i);
      ramp_sel <= 4'(10 - i);
      step(4);
      check("min_freq", 32'(fmin), 32'(fmin_tab[i]));
      check("ramp", 32'(ramp), 32'(ramp_tab[10 - i]));
      wb(reg_drive_ofs, 1'b0, 32'h0);
      check("drive_reg", q, 32'(ramp_tab[10 - i] << 8 | fmin_tab[i]));
    end
    wb(reg_control_ofs, 1'b1, 32'h5);
    step(4);
    check("bus_ramp", 32'(ramp), 32'd100);
    wb(reg_control_ofs, 1'b1, 32'h1);
    for (int k = 0; k < 4; k++) begin
      dir_in <= direction_type'(k[1:0]);
      step(5);
      check("gate", 32'(gate), 32'({k != 0, k[1], k[0]}));
    end
    load(1'b0, 8'h25, 4'h3);
    load(1'b0, 8'h03, 4'h4);
    repeat (4) load(1'b0, 8'($random(seed)), 4'($random(seed)));
    load(1'b1, 8'hFE, 4'hA);
    step(12);
    check("gw_fault_on", 32'(lamps.fault), 32'h1);
    wb(reg_control_ofs, 1'b1, 32'h3);
    step(3);
    check("gw_fault_off", 32'(lamps.fault), 32'h0);
    load(1'b1, 8'h27, 4'h1);
    load(1'b1, 8'hF8, 4'h0);
    load(1'b1, 8'hFE, 4'hB);
    final_report();
  end
endmodule : testbench
